// File: include/cifc_params.svh
/*
 * Register map, field positions and reset values of the CAN interrupt
 * and acceptance filter configuration block.
 * Assumes a 32-bit AHB-Lite bus with each register in one aligned word.
 */
`ifndef CIFC_PARAMS_SVH
`define CIFC_PARAMS_SVH

// Byte offsets of the registers
`define CIFC_OFS_FLAGS      12'h000
`define CIFC_OFS_ENABLES    12'h004
`define CIFC_OFS_MSKSEL     12'h008
`define CIFC_OFS_MATCH      12'h00c
`define CIFC_OFS_MASK0      12'h010
`define CIFC_OFS_MASK1      12'h014
`define CIFC_OFS_MASK2      12'h018
`define CIFC_OFS_FILT_BASE  12'h040
`define CIFC_OFS_FILT_LAST  12'h07c

// Flag and enable bit positions
`define CIFC_BIT_TBUF       0
`define CIFC_BIT_RBUF       1
`define CIFC_BIT_RBOV       2
`define CIFC_BIT_FIFO       3
`define CIFC_BIT_ERR        5
`define CIFC_BIT_WAKE       6
`define CIFC_BIT_IVR        7

// Implemented bits and reset values
`define CIFC_FLAG_IMPL      16'h00ef
`define CIFC_EN_IMPL        16'h00ef
`define CIFC_FLAGS_RST      16'h0000
`define CIFC_EN_RST         16'h0000
`define CIFC_MSKSEL_RST     16'h0000
`define CIFC_MASK_RST       16'h0000
`define CIFC_FILT_RST       16'h0000

// Mask source codes
`define CIFC_SRC_MASK0      2'h0
`define CIFC_SRC_MASK1      2'h1
`define CIFC_SRC_MASK2      2'h2
`define CIFC_SRC_NONE       2'h3

`endif

// File: include/cifc_pkg.sv
/*
 * Types shared by the CAN interrupt and filter configuration block.
 * Assumes cifc_params.svh provides the numeric constants.
 */
package cifc_pkg;
    typedef logic [15:0] cifc_word_t;
    typedef logic [1:0]  cifc_msrc_t;
    typedef enum logic [1:0] {
        CIFC_IDLE  = 2'b01,
        CIFC_WRITE = 2'b10
    } cifc_phase_t;
endpackage

// File: rtl/cifc_filter_mem.sv
/*
 * Sixteen-entry store of extended identifier match values.
 * Assumes one write port and one registered read port on clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module cifc_filter_mem
    import cifc_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic          clk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire cifc_word_t    wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output cifc_word_t         rdata_o,
    output cifc_word_t         all_o [DEPTH]
);
    // No reset: contents undefined after reset by design
    cifc_word_t mem_reg [DEPTH];

    // Write port and registered read
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_reg[waddr_i] <= wdata_i;
        end
        rdata_o <= mem_reg[raddr_i];
    end

    // Whole array for the comparators
    assign all_o = mem_reg;
endmodule // cifc_filter_mem
`default_nettype wire

// File: rtl/cifc_core.sv
/*
 * CAN interrupt flags, enables and acceptance filter configuration,
 * reached over AHB-Lite, with a live match check of a presented ID.
 * Assumes single-word AHB-Lite transfers and one clock domain; event
 * inputs are single-cycle pulses from logic on clk_i.
 */
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cifc_params.svh"
module cifc_core
    import cifc_pkg::*;
#(
    parameter int NFILT = 16,
    parameter int NSEL  = 8
) (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic [7:0]  irq_event_i,
    input  wire cifc_word_t  msg_ext_id_i,
    output logic      [15:0] filter_hit_o,
    output logic             irq_o
);
    // Address phase capture
    logic        wr_pend_reg;
    logic        rd_pend_reg;
    logic [11:0] addr_reg;
    cifc_phase_t phase_reg;
    logic [31:0] rdata_reg;

    wire logic take_w = hsel_i & hready_i & htrans_i[1];
    wire logic wr_en  = wr_pend_reg;

    // Registers
    cifc_word_t flags_reg;
    cifc_word_t en_reg;
    cifc_word_t msksel_reg;
    cifc_word_t mask_reg [3];
    cifc_word_t filt_all [NFILT];
    cifc_word_t filt_rd;

    // Decode of the pending data phase address
    wire logic hit_flags  = addr_reg == `CIFC_OFS_FLAGS;
    wire logic hit_en     = addr_reg == `CIFC_OFS_ENABLES;
    wire logic hit_msksel = addr_reg == `CIFC_OFS_MSKSEL;
    wire logic hit_match  = addr_reg == `CIFC_OFS_MATCH;
    wire logic hit_m0     = addr_reg == `CIFC_OFS_MASK0;
    wire logic hit_m1     = addr_reg == `CIFC_OFS_MASK1;
    wire logic hit_m2     = addr_reg == `CIFC_OFS_MASK2;
    wire logic hit_filt   = (addr_reg >= `CIFC_OFS_FILT_BASE) &&
                            (addr_reg <= `CIFC_OFS_FILT_LAST);
    wire logic [3:0] filt_idx = addr_reg[5:2];
    wire cifc_word_t wdat = hwdata_i[15:0];

    // Always ready, always OKAY; writes land in the data phase
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign hrdata_o    = rdata_reg;

    // Bus phase tracking
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg    <= 12'h000;
            phase_reg   <= CIFC_IDLE;
        end else begin
            wr_pend_reg <= take_w & hwrite_i;
            rd_pend_reg <= take_w & ~hwrite_i;
            if (take_w) begin
                addr_reg <= haddr_i[11:0];
            end
            phase_reg <= (take_w & hwrite_i) ? CIFC_WRITE : CIFC_IDLE;
        end
    end

    // Read data is registered at the address phase edge
    wire logic [11:0] raddr = haddr_i[11:0];
    wire logic r_flags  = raddr == `CIFC_OFS_FLAGS;
    wire logic r_en     = raddr == `CIFC_OFS_ENABLES;
    wire logic r_msksel = raddr == `CIFC_OFS_MSKSEL;
    wire logic r_match  = raddr == `CIFC_OFS_MATCH;
    wire logic r_m0     = raddr == `CIFC_OFS_MASK0;
    wire logic r_m1     = raddr == `CIFC_OFS_MASK1;
    wire logic r_m2     = raddr == `CIFC_OFS_MASK2;
    wire logic r_filt   = (raddr >= `CIFC_OFS_FILT_BASE) &&
                          (raddr <= `CIFC_OFS_FILT_LAST);
    logic r_filt_reg;

    cifc_word_t rmux;
    always_comb begin
        rmux = 16'h0000;
        case (1'b1)
            r_flags:  rmux = flags_reg;
            r_en:     rmux = en_reg;
            r_msksel: rmux = msksel_reg;
            r_match:  rmux = filter_hit_o;
            r_m0:     rmux = mask_reg[0];
            r_m1:     rmux = mask_reg[1];
            r_m2:     rmux = mask_reg[2];
            r_filt:   rmux = filt_all[raddr[5:2]];
            default:  rmux = 16'h0000;
        endcase
    end

    // Filter reads come from the array, registered on the same edge as the rest
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_reg  <= 32'h0000_0000;
            r_filt_reg <= 1'b0;
        end else begin
            r_filt_reg <= take_w & ~hwrite_i & r_filt;
            if (take_w & ~hwrite_i) begin
                rdata_reg <= {16'h0000, rmux};
            end
        end
    end

    // Match store, registered read
    cifc_filter_mem #(
        .DEPTH (NFILT),
        .AW    (4)
    ) u_mem (
        .clk_i   (clk_i),
        .we_i    (wr_en & hit_filt),
        .waddr_i (filt_idx),
        .wdata_i (wdat),
        .raddr_i (haddr_i[5:2]),
        .rdata_o (filt_rd),
        .all_o   (filt_all)
    );

    // Flags: hardware set wins over write-one-to-clear
    wire cifc_word_t ev_set = {8'h00, irq_event_i} & `CIFC_FLAG_IMPL;
    wire cifc_word_t w1c    = (wr_en & hit_flags) ? wdat : 16'h0000;
    wire cifc_word_t flags_next = (flags_reg & ~w1c) | ev_set;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flags_reg <= `CIFC_FLAGS_RST;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // Enables, mask source selects and masks
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            en_reg      <= `CIFC_EN_RST;
            msksel_reg  <= `CIFC_MSKSEL_RST;
            mask_reg[0] <= `CIFC_MASK_RST;
            mask_reg[1] <= `CIFC_MASK_RST;
            mask_reg[2] <= `CIFC_MASK_RST;
        end else begin
            if (wr_en & hit_en) begin
                en_reg <= wdat & `CIFC_EN_IMPL;
            end
            if (wr_en & hit_msksel) begin
                msksel_reg <= wdat;
            end
            if (wr_en & hit_m0) begin
                mask_reg[0] <= wdat;
            end
            if (wr_en & hit_m1) begin
                mask_reg[1] <= wdat;
            end
            if (wr_en & hit_m2) begin
                mask_reg[2] <= wdat;
            end
        end
    end

    // Interrupt: set flag gated by its enable, flag kept when masked off
    assign irq_o = |(flags_reg & en_reg);

    // Per filter compare; filters 8 to 15 compare every bit
    genvar gi;
    generate
        for (gi = 0; gi < NFILT; gi++) begin : g_filt
            cifc_msrc_t src;
            cifc_word_t care;
            if (gi < NSEL) begin : g_sel
                assign src = msksel_reg[2*gi +: 2];
            end else begin : g_nosel
                assign src = `CIFC_SRC_NONE;
            end
            // Code 3 leaves every bit compared
            assign care = (src == `CIFC_SRC_MASK0) ? mask_reg[0] :
                          (src == `CIFC_SRC_MASK1) ? mask_reg[1] :
                          (src == `CIFC_SRC_MASK2) ? mask_reg[2] :
                          16'hffff;
            // Bitwise equality of ones and zeros
            assign filter_hit_o[gi] =
                ~|((filt_all[gi] ^ msg_ext_id_i) & care);
        end
    endgenerate

    // Unused fields kept visible for lint
    wire logic unused = &{1'b0, hsize_i, haddr_i[31:12], hwdata_i[31:16],
                          rd_pend_reg, phase_reg, r_filt_reg, filt_rd,
                          hit_match};
endmodule // cifc_core
`default_nettype wire

// File: verif/cifc_core_monitor.sv
/* Port checker for cifc_core, bound below.
   Assumes one clock, a single AHB-Lite master and register map macros. */
`timescale 1ns/1ps
`default_nettype none
`include "cifc_params.svh"
module cifc_core_monitor
    import cifc_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic        hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    input wire logic [7:0]  irq_event_i,
    input wire logic        irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    logic        wr_dp;
    logic [11:0] a_dp;
    wire take  = hsel_i & hready_i & htrans_i[1];
    wire en_dp = wr_dp && a_dp == `CIFC_OFS_ENABLES;
    wire fl_dp = wr_dp && a_dp == `CIFC_OFS_FLAGS;
    wire quiet = haddr_i[11:0] == 12'h020;
    // Write data phase tracker, so hwdata is seen with its address
    always_ff @(posedge clk_i or negedge resetn_i)
        if (!resetn_i) wr_dp <= 1'b0;
        else wr_dp <= take & hwrite_i;
    always_ff @(posedge clk_i) if (take) a_dp <= haddr_i[11:0];
    property p_ready; hreadyout_o; endproperty
    a_ready: assert property (p_ready) else $error("wait state seen");
    property p_okay; !hresp_o; endproperty
    a_okay: assert property (p_okay) else $error("error response seen");
    property p_hi; hrdata_o[31:16] == 16'h0000; endproperty
    a_hi: assert property (p_hi) else $error("upper read bits set");
    property p_rd_hold; !$past(take && !hwrite_i) |-> $stable(hrdata_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_quiet; take && !hwrite_i && quiet |=> hrdata_o == 32'h0;
    endproperty
    a_quiet: assert property (p_quiet) else $error("hidden read not 0");
    property p_rise; $rose(irq_o) |-> $past(irq_event_i) != 8'h00 ||
        $past(wr_dp); endproperty
    a_rise: assert property (p_rise) else $error("irq rose alone");
    property p_fall; $fell(irq_o) |-> $past(wr_dp); endproperty
    a_fall: assert property (p_fall) else $error("irq fell alone");
    property p_en_off; en_dp && hwdata_i[15:0] == 16'h0 |=> !irq_o;
    endproperty
    a_en_off: assert property (p_en_off) else $error("masked irq");
    property p_fl_clr; fl_dp && hwdata_i[15:0] == `CIFC_FLAG_IMPL &&
        irq_event_i == 8'h00 |=> !irq_o; endproperty
    a_fl_clr: assert property (p_fl_clr) else $error("flags kept");
    c_rise: cover property ($rose(irq_o));
    c_en: cover property (en_dp);
    c_clr: cover property (fl_dp);
endmodule // cifc_core_monitor
bind cifc_core cifc_core_monitor u_mon (.*);
`default_nettype wire

// File: verif/cifc_can_node.sv
/* Far-side node model: event pulses and received identifiers.
   Assumes the bench requests each event for a single cycle. */
`timescale 1ns/1ps
`default_nettype none
module cifc_can_node
    import cifc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic [7:0] ev_req_i,
    input  wire cifc_word_t id_req_i,
    output logic      [7:0] irq_event_o,
    output cifc_word_t      id_o
);
    // Registered, so pulses leave just after an edge like real logic
    always_ff @(posedge clk_i) begin
        irq_event_o <= ev_req_i;
        id_o        <= id_req_i;
    end
endmodule // cifc_can_node
`default_nettype wire

// File: verif/tb.sv
/* Self-checking bench for cifc_core with a node model on the far side.
   Assumes the one slave's hreadyout is the bus's hready. */
`timescale 1ns/1ps
`default_nettype none
`include "cifc_params.svh"
`define CHK(e, a) begin exp_q.push_back(32'(e)); got_q.push_back(32'(a)); end
module tb;
    import cifc_pkg::*;
    logic        clk_i = 0, resetn_i = 0, hsel_i = 0, hwrite_i = 0;
    logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, r, v;
    logic [1:0]  htrans_i = 0;
    logic [2:0]  hsize_i = 0;
    logic [7:0]  ev_req = 0, irq_event_i;
    cifc_word_t  id_req = 0, msg_ext_id_i, m, sel, e;
    logic [15:0] filter_hit_o;
    logic        hreadyout_o, hresp_o, irq_o;
    logic [31:0] exp_q[$], got_q[$];
    logic [11:0] ofs [5] = '{`CIFC_OFS_FLAGS, `CIFC_OFS_ENABLES,
                             `CIFC_OFS_MSKSEL, 12'h020, `CIFC_OFS_MASK0};
    logic [15:0] flips [3] = '{16'h0000, 16'h8000, 16'h0001};
    int          num_errors = 0, tests_run = 0, seed = 32'hd230;
    initial forever #20 clk_i = ~clk_i;
    cifc_can_node node (.clk_i(clk_i), .ev_req_i(ev_req), .id_req_i(id_req),
        .irq_event_o(irq_event_i), .id_o(msg_ext_id_i));
    cifc_core dut (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
        .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .irq_event_i(irq_event_i), .msg_ext_id_i(msg_ext_id_i),
        .filter_hit_o(filter_hit_o), .irq_o(irq_o));
    // One single word transfer; ends past the edge so updates have landed
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        hsel_i <= 1'b1;
        haddr_i <= {20'h0, a};
        htrans_i <= 2'b10;
        hwrite_i <= w;
        hsize_i <= 3'b010;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'b00;
        hsel_i <= 1'b0;
        hwdata_i <= d;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        r = hrdata_o;
        @(negedge clk_i);
    endtask
    task pulse(input int b);
        @(posedge clk_i);
        ev_req <= 8'h01 << b;
        @(posedge clk_i);
        ev_req <= 8'h00;
        repeat (3) @(posedge clk_i);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Oldest note against oldest observation
    initial forever begin
        wait (got_q.size() != 0);
        tests_run++;
        if (got_q[0] !== exp_q[0]) begin
            num_errors++;
            $display("mismatch t=%0t exp=%h got=%h", $time, exp_q[0], got_q[0]);
        end
        void'(exp_q.pop_front());
        void'(got_q.pop_front());
    end
    initial begin
        #(40 * 20000);
        num_errors++;
        final_report;
    end
    initial begin
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            bus(0, ofs[i], 0);
            `CHK(0, r)
        end
        `CHK(0, irq_o)
        $display("test reset done");
        v = $random(seed);
        bus(1, `CIFC_OFS_ENABLES, v);
        bus(0, `CIFC_OFS_ENABLES, 0);
        `CHK(v[15:0] & `CIFC_EN_IMPL, r)
        bus(1, `CIFC_OFS_ENABLES, 0);
        // Every source: recorded while masked, gated, then cleared
        for (int b = 0; b < 8; b++) begin
            e = (16'h0001 << b) & `CIFC_FLAG_IMPL;
            pulse(b);
            bus(0, `CIFC_OFS_FLAGS, 0);
            `CHK(e, r)
            `CHK(0, irq_o)
            bus(1, `CIFC_OFS_ENABLES, 32'h1 << b);
            `CHK(e != 0, irq_o)
            bus(1, `CIFC_OFS_ENABLES, 0);
            `CHK(0, irq_o)
            bus(1, `CIFC_OFS_FLAGS, 32'h00ef);
            bus(0, `CIFC_OFS_FLAGS, 0);
            `CHK(0, r)
        end
        $display("test interrupts done");
        bus(1, `CIFC_OFS_MASK0, 32'hffff);
        bus(1, `CIFC_OFS_MASK1, 32'h00ff);
        bus(1, `CIFC_OFS_MASK2, 0);
        v = $random(seed);
        for (int k = 0; k < 9; k++) bus(1, `CIFC_OFS_FILT_BASE + 12'(k * 4), v);
        bus(0, `CIFC_OFS_FILT_BASE + 12'h00c, 0);
        `CHK(v[15:0], r)
        // One selector field at a time; others code 3, all bits compared
        for (int k = 0; k < 8; k++) begin
            for (int c = 0; c < 4; c++) begin
                sel = 16'hffff;
                sel[2 * k +: 2] = 2'(c);
                bus(1, `CIFC_OFS_MSKSEL, sel);
                bus(0, `CIFC_OFS_MSKSEL, 0);
                `CHK(sel, r)
                m = c == 1 ? 16'h00ff : c == 2 ? 16'h0000 : 16'hffff;
                for (int j = 0; j < 3; j++) begin
                    @(posedge clk_i);
                    id_req <= v[15:0] ^ flips[j];
                    repeat (2) @(posedge clk_i);
                    e = {16{flips[j] == 16'h0}};
                    e[k] = (flips[j] & m) == 16'h0;
                    `CHK(e[8:0], filter_hit_o[8:0])
                end
            end
        end
        $display("test filters done");
        @(posedge clk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        bus(0, `CIFC_OFS_MSKSEL, 0);
        `CHK(0, r)
        $display("test second reset done");
        #1;
        final_report;
    end
endmodule // tb
`default_nettype wire
